// [src/acl_defs.vh]
`ifndef ACL_DEFS_VH
`define ACL_DEFS_VH

// register byte addresses
`define ACL_REG_DATA      8'h00
`define ACL_REG_CMD       8'h04
`define ACL_REG_STATUS    8'h08
`define ACL_REG_IRQ_STAT  8'h0C
`define ACL_REG_IRQ_MASK  8'h10

// command byte layout
`define ACL_CMD_SVC       7

// opcodes, seven bits below the service request flag
`define ACL_OP_FIX32      7'h1E
`define ACL_OP_FIX16      7'h1F
`define ACL_OP_FLT32      7'h1C
`define ACL_OP_FLT16      7'h1D
`define ACL_OP_FLOAT_MULTIPLY_CMD       7'h12
`define ACL_OP_FLOAT_SUBTRACT_CMD       7'h11
`define ACL_OP_LOG        7'h08
`define ACL_OP_LN         7'h09
`define ACL_OP_NOP        7'h00
`define ACL_OP_ROTW_A     7'h18
`define ACL_OP_ROTW_B     7'h19
`define ACL_OP_ROTN       7'h78
`define ACL_OP_DUPW_A     7'h37
`define ACL_OP_DUPW_B     7'h17

// status byte fields
`define ACL_ST_BUSY       7
`define ACL_ST_SIGN       6
`define ACL_ST_ZERO       5
`define ACL_ST_ERR_HI     4
`define ACL_ST_ERR_LO     1
`define ACL_ST_CARRY      0
`define ACL_ST_RESET      7'h00

// error field codes
`define ACL_ERR_NONE      4'h0
`define ACL_ERR_NEG       4'h4
`define ACL_ERR_OVF       4'h8
`define ACL_ERR_UNF       4'h2

// interrupt status and mask bits
`define ACL_IRQ_DONE      0
`define ACL_IRQ_ERR       1
`define ACL_IRQ_SVC       2
`define ACL_IRQ_MASK_RST  3'h0

// execution times in core clock cycles
`define ACL_CYC_FIX32     16'h005A
`define ACL_CYC_FIX16     16'h005A
`define ACL_CYC_FLT32     16'h003E
`define ACL_CYC_FLT16     16'h003E
`define ACL_CYC_FLOAT_MULTIPLY_CMD      16'h0092
`define ACL_CYC_FLOAT_SUBTRACT_CMD      16'h0046
`define ACL_CYC_FLOAT_SUBTRACT_CMD_Z    16'h001A
`define ACL_CYC_LOG_BAD   16'h0014
`define ACL_CYC_NOP       16'h0004
`define ACL_CYC_ROTW      16'h000C
`define ACL_CYC_ROTN      16'h000C
`define ACL_CYC_DUPW      16'h0014

// logarithm scale factors, fraction of 2^24
`define ACL_K_LN2         24'hB1_7218
`define ACL_K_LG2         24'h4D_104D

`endif

// [src/acl_core.v]
// Behaviour
// - float to int32 in place, D cleared
// - int32 overflow: flag it, keep A
// - int16 result in low half, move up
// - int16 overflow: flag it, keep A
// - int32 to float in place, D cleared
// - int16 to float split, stack down
// - float multiply onto NEXT_ON_STACK, move up
// - exponent out of range: error, wrapped exponent
// - float subtract B minus A, timing
// - common log, non-positive gives 0100
// - natural log, non-positive quick error
// - no-op clears whole status byte
// - wide rotate up, fixed time
// - narrow rotate up by two bytes
// - duplicate wide top, D lost
// - sign and zero from result
`timescale 1ns/1ps
`default_nettype none
`include "acl_defs.vh"

module acl_core #(
  parameter LN_CYCLES  = 4298,
  parameter LOG_CYCLES = 4298
) (
  input  wire        core_clk,
  input  wire        rst_b,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         svcReq,
  output reg         irq
);

  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  reg [7:0]  stk [0:15];
  reg [3:0]  tp;
  reg        state;
  reg [15:0] cnt;
  reg [7:0]  cmd;
  reg [6:0]  status;
  reg [2:0]  irqStat;
  reg [2:0]  irqMask;
  integer    k;

  // ring seen from the top, MS byte first; kept as nets because a
  // function reading the array never wakes a continuous assign
  wire [127:0] ring;
  wire [255:0] ringRot;
  wire [127:0] view;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : ringByte
      assign ring[127 - 8*g -: 8] = stk[g];
    end
  endgenerate
  assign ringRot = {ring, ring} << {tp, 3'b000};
  assign view    = ringRot[255:128];

  // value = mag * 2^(e-32); returns {unf, ovf, float}
  function [33:0] norm;
    input              s;
    input signed [9:0] e;
    input [31:0]       mag;
    reg   [31:0]       sh;
    reg   [5:0]        n;
    reg signed [9:0]   ex;
    integer            i;
    begin
      sh = mag;
      n = 6'h00;
      for (i = 0; i < 31; i = i + 1) begin
        if (!sh[31]) begin
          sh = {sh[30:0], 1'b0};
          n = n + 6'h01;
        end
      end
      ex = e - $signed({4'h0, n});
      if (mag == 32'h0000_0000)
        norm = {2'b00, 32'h0000_0000};
      else
        norm = {ex < -10'sd64, ex > 10'sd63, s, ex[6:0], sh[31:8]};
    end
  endfunction

  wire [6:0]  op     = cmd[6:0];
  wire [31:0] opA    = view[127:96];
  wire [31:0] opB    = view[95:64];
  wire [15:0] opA16  = view[127:112];
  wire [15:0] opB16  = view[111:96];
  wire signed [9:0] expA = {{3{opA[30]}}, opA[30:24]};
  wire signed [9:0] expB = {{3{opB[30]}}, opB[30:24]};
  wire [23:0] manA   = opA[23:0];
  wire [23:0] manB   = opB[23:0];
  wire        zeroA  = (opA == 32'h0000_0000);
  wire        zeroB  = (opB == 32'h0000_0000);

  // float to integer, truncating toward zero
  wire [55:0] fixWide = {32'h0000_0000, manA} << expA[4:0];
  wire [31:0] fixMag  = (expA > 10'sd0) ? fixWide[55:24] : 32'h0000_0000;
  wire [31:0] fixInt  = opA[31] ? (~fixMag + 32'h0000_0001) : fixMag;
  wire        ovf32   = expA > 10'sd31;
  wire        ovf16   = expA > 10'sd15;

  // integer to float
  wire [31:0] absA32  = opA[31] ? (~opA + 32'h0000_0001) : opA;
  wire [15:0] absA16  = opA16[15] ? (~opA16 + 16'h0001) : opA16;
  wire [33:0] flt32   = norm(opA[31], 10'sd32, absA32);
  wire [33:0] flt16   = norm(opA16[15], 10'sd16, {absA16, 16'h0000});

  // multiply
  wire [47:0] prod    = manA * manB;
  wire [33:0] mulRes  = norm(opA[31] ^ opB[31], expA + expB, prod[47:16]);

  // subtract: align smaller operand, signed sum of magnitudes
  wire        aBig    = expA > expB;
  wire [9:0]  expGap  = aBig ? expA - expB : expB - expA;
  wire [30:0] algA    = aBig ? {manA, 7'h00} : ({manA, 7'h00} >> expGap);
  wire [30:0] algB    = aBig ? ({manB, 7'h00} >> expGap) : {manB, 7'h00};
  wire [32:0] valA    = opA[31] ? {2'b00, algA} : (~{2'b00, algA} + 33'h1);
  wire [32:0] valB    = opB[31] ? (~{2'b00, algB} + 33'h1) : {2'b00, algB};
  wire [32:0] dif     = valB + valA;
  wire [31:0] difMag  = dif[32] ? (~dif[31:0] + 32'h0000_0001) : dif[31:0];
  wire signed [9:0] expTop = (aBig ? expA : expB) + 10'sd1;
  wire [33:0] subRes  = zeroA ? {2'b00, opB} :
                        zeroB ? {2'b00, ~opA[31], opA[30:0]} :
                        norm(dif[32], expTop, difMag);

  // log: piecewise linear log2 of mantissa, scaled; coarse accuracy
  wire [31:0] logLin  = ({{22{expA[9]}}, expA} << 23) +
                        {8'h00, manA} - 32'h0100_0000;
  wire [31:0] logAbs  = logLin[31] ? (~logLin + 32'h0000_0001) : logLin;
  wire [23:0] logK    = (op == `ACL_OP_LN) ? `ACL_K_LN2 : `ACL_K_LG2;
  wire [55:0] logProd = logAbs * logK;
  wire [33:0] logRes  = norm(logLin[31], 10'sd9, logProd[55:24]);
  wire        logBad  = opA[31] | zeroA;

  wire        busy    = (state == ST_EXEC);
  wire        commit  = busy && (cnt == 16'h0001);

  function known;
    input [6:0] c;
    begin
      case (c)
        `ACL_OP_FIX32, `ACL_OP_FIX16, `ACL_OP_FLT32, `ACL_OP_FLT16,
        `ACL_OP_FLOAT_MULTIPLY_CMD, `ACL_OP_FLOAT_SUBTRACT_CMD, `ACL_OP_LOG, `ACL_OP_LN,
        `ACL_OP_NOP, `ACL_OP_ROTW_A, `ACL_OP_ROTW_B, `ACL_OP_ROTN,
        `ACL_OP_DUPW_A, `ACL_OP_DUPW_B: known = 1'b1;
        default: known = 1'b0;
      endcase
    end
  endfunction

  // execution length, chosen once the command byte is latched
  reg [15:0] runLen;
  always @* begin
    case (op)
      `ACL_OP_FIX32:  runLen = `ACL_CYC_FIX32;
      `ACL_OP_FIX16:  runLen = `ACL_CYC_FIX16;
      `ACL_OP_FLT32:  runLen = `ACL_CYC_FLT32;
      `ACL_OP_FLT16:  runLen = `ACL_CYC_FLT16;
      `ACL_OP_FLOAT_MULTIPLY_CMD:   runLen = `ACL_CYC_FLOAT_MULTIPLY_CMD;
      `ACL_OP_FLOAT_SUBTRACT_CMD:   runLen = zeroA ? `ACL_CYC_FLOAT_SUBTRACT_CMD_Z : `ACL_CYC_FLOAT_SUBTRACT_CMD;
      `ACL_OP_LOG:    runLen = logBad ? `ACL_CYC_LOG_BAD : LOG_CYCLES[15:0];
      `ACL_OP_LN:     runLen = logBad ? `ACL_CYC_LOG_BAD : LN_CYCLES[15:0];
      `ACL_OP_ROTW_A: runLen = `ACL_CYC_ROTW;
      `ACL_OP_ROTW_B: runLen = `ACL_CYC_ROTW;
      `ACL_OP_ROTN:   runLen = `ACL_CYC_ROTN;
      `ACL_OP_DUPW_A: runLen = `ACL_CYC_DUPW;
      `ACL_OP_DUPW_B: runLen = `ACL_CYC_DUPW;
      default:        runLen = `ACL_CYC_NOP;
    endcase
  end

  // error field of the finishing command
  reg [3:0] cmdErr;
  always @* begin
    case (op)
      `ACL_OP_FIX32: cmdErr = ovf32 ? `ACL_ERR_OVF : `ACL_ERR_NONE;
      `ACL_OP_FIX16: cmdErr = ovf16 ? `ACL_ERR_OVF : `ACL_ERR_NONE;
      `ACL_OP_FLOAT_MULTIPLY_CMD:  cmdErr = mulRes[32] ? `ACL_ERR_OVF :
                              mulRes[33] ? `ACL_ERR_UNF : `ACL_ERR_NONE;
      `ACL_OP_FLOAT_SUBTRACT_CMD:  cmdErr = subRes[32] ? `ACL_ERR_OVF :
                              subRes[33] ? `ACL_ERR_UNF : `ACL_ERR_NONE;
      `ACL_OP_LOG,
      `ACL_OP_LN:    cmdErr = logBad ? `ACL_ERR_NEG : `ACL_ERR_NONE;
      default:       cmdErr = `ACL_ERR_NONE;
    endcase
  end

  // bus decode, evaluated in the first access cycle
  wire       rdData = (paddr == `ACL_REG_DATA);
  wire       rdCmd  = (paddr == `ACL_REG_CMD);
  reg        decErr;
  reg [31:0] decData;
  always @* begin
    decErr = 1'b0;
    decData = 32'h0000_0000;
    case (paddr)
      `ACL_REG_DATA: begin
        decErr = busy;
        decData = {24'h00_0000, view[127:120]};
      end
      `ACL_REG_CMD: begin
        decErr = pwrite && (busy || !known(pwdata[6:0]));
        decData = {24'h00_0000, cmd};
      end
      `ACL_REG_STATUS: begin
        decErr = pwrite;
        decData = {24'h00_0000, busy, status};
      end
      `ACL_REG_IRQ_STAT: begin
        decErr = pwrite;
        decData = {29'h0000_0000, irqStat};
      end
      `ACL_REG_IRQ_MASK: decData = {29'h0000_0000, irqMask};
      default: decErr = 1'b1;
    endcase
  end

  wire done   = psel && penable && pready && !pslverr;
  wire wrDone = done && pwrite;
  wire rdDone = done && !pwrite;

  // set wins: only bits already returned by the read are cleared
  wire [2:0] evt;
  assign evt[`ACL_IRQ_DONE] = commit;
  assign evt[`ACL_IRQ_ERR]  = commit && (cmdErr != `ACL_ERR_NONE);
  assign evt[`ACL_IRQ_SVC]  = commit && cmd[`ACL_CMD_SVC];
  wire [2:0] clr = (rdDone && paddr == `ACL_REG_IRQ_STAT) ?
                   prdata[2:0] : 3'h0;
  wire [2:0] next_irqStat = (irqStat & ~clr) | evt;
  wire [2:0] next_irqMask = (wrDone && paddr == `ACL_REG_IRQ_MASK) ?
                            pwdata[2:0] : irqMask;

  task put32;
    input [3:0]  o;
    input [31:0] v;
    begin
      stk[tp + o]        <= v[31:24];
      stk[tp + o + 4'h1] <= v[23:16];
      stk[tp + o + 4'h2] <= v[15:8];
      stk[tp + o + 4'h3] <= v[7:0];
    end
  endtask

  task put16;
    input [3:0]  o;
    input [15:0] v;
    begin
      stk[tp + o]        <= v[15:8];
      stk[tp + o + 4'h1] <= v[7:0];
    end
  endtask

  task flags;
    input s;
    input z;
    begin
      status[`ACL_ST_SIGN] <= s;
      status[`ACL_ST_ZERO] <= z;
      status[`ACL_ST_ERR_HI:`ACL_ST_ERR_LO] <= cmdErr;
      status[`ACL_ST_CARRY] <= 1'b0;
    end
  endtask

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (k = 0; k < 16; k = k + 1)
        stk[k] <= 8'h00;
      tp      <= 4'h0;
      state   <= ST_IDLE;
      cnt     <= 16'h0000;
      cmd     <= 8'h00;
      status  <= `ACL_ST_RESET;
      irqStat <= 3'h0;
      irqMask <= `ACL_IRQ_MASK_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      svcReq  <= 1'b0;
      irq     <= 1'b0;
    end else begin
      // one wait state: answer registered in the first access cycle
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : decData;
        pslverr <= decErr;
      end else if (pready) begin
        pslverr <= 1'b0;
      end
      irqStat <= next_irqStat;
      irqMask <= next_irqMask;
      irq     <= |(next_irqStat & next_irqMask);

      if (done && rdData) begin
        if (pwrite) begin
          tp <= tp - 4'h1;
          stk[tp - 4'h1] <= pwdata[7:0];
        end else begin
          tp <= tp + 4'h1;
        end
      end
      if (wrDone && rdCmd) begin
        cmd    <= pwdata[7:0];
        svcReq <= 1'b0;
        state  <= ST_EXEC;
        cnt    <= 16'h0000;
      end

      case (state)
        ST_IDLE: begin
        end
        ST_EXEC: begin
          if (cnt == 16'h0000) begin
            cnt <= runLen;
          end else if (cnt != 16'h0001) begin
            cnt <= cnt - 16'h0001;
          end else begin
            state <= ST_IDLE;
            cnt   <= 16'h0000;
            if (cmd[`ACL_CMD_SVC])
              svcReq <= 1'b1;
            case (op)
              `ACL_OP_FIX32: begin
                put32(4'hC, 32'h0000_0000);
                if (ovf32) begin
                  flags(opA[31], zeroA);
                end else begin
                  put32(4'h0, fixInt);
                  flags(fixInt[31], fixInt == 32'h0000_0000);
                end
              end
              `ACL_OP_FIX16: begin
                put32(4'hC, 32'h0000_0000);
                if (ovf16) begin
                  flags(opA[31], zeroA);
                end else begin
                  put16(4'h2, fixInt[15:0]);
                  tp <= tp + 4'h2;
                  flags(fixInt[15], fixInt[15:0] == 16'h0000);
                end
              end
              `ACL_OP_FLT32: begin
                put32(4'h0, flt32[31:0]);
                put32(4'hC, 32'h0000_0000);
                flags(flt32[31], flt32[31:0] == 32'h0000_0000);
              end
              `ACL_OP_FLT16: begin
                put16(4'h0, flt16[15:0]);
                put16(4'hE, flt16[31:16]);
                put32(4'hA, 32'h0000_0000);
                tp <= tp - 4'h2;
                flags(flt16[31], flt16[31:0] == 32'h0000_0000);
              end
              `ACL_OP_FLOAT_MULTIPLY_CMD: begin
                put32(4'h4, mulRes[31:0]);
                tp <= tp + 4'h4;
                flags(mulRes[31], mulRes[31:0] == 32'h0000_0000);
              end
              `ACL_OP_FLOAT_SUBTRACT_CMD: begin
                put32(4'h4, subRes[31:0]);
                tp <= tp + 4'h4;
                flags(subRes[31], subRes[31:0] == 32'h0000_0000);
              end
              `ACL_OP_LOG,
              `ACL_OP_LN: begin
                put32(4'h8, 32'h0000_0000);
                put32(4'hC, 32'h0000_0000);
                if (logBad) begin
                  flags(opA[31], zeroA);
                end else begin
                  put32(4'h0, logRes[31:0]);
                  flags(logRes[31], logRes[31:0] == 32'h0000_0000);
                end
              end
              `ACL_OP_ROTW_A,
              `ACL_OP_ROTW_B: begin
                tp <= tp + 4'h4;
                flags(opB[31], zeroB);
              end
              `ACL_OP_ROTN: begin
                tp <= tp + 4'h2;
                flags(opB16[15], opB16 == 16'h0000);
              end
              `ACL_OP_DUPW_A,
              `ACL_OP_DUPW_B: begin
                put32(4'hC, opA);
                tp <= tp - 4'h4;
                flags(opA[31], zeroA);
              end
              default: status <= `ACL_ST_RESET;
            endcase
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// [verification/acl_core_properties.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acl_defs.vh"
module acl_props #(
  parameter LN_CYCLES  = 4298,
  parameter LOG_CYCLES = 4298
) (
  input wire logic        core_clk,
  input wire logic        rst_b,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        svcReq,
  input wire logic        irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic acc;
  logic lastSvc;
  assign acc = psel && penable && pready;
  // flag of the command now running; no second one is taken while busy
  always @(posedge core_clk or negedge rst_b)
    if (!rst_b)
      lastSvc <= 1'b0;
    else if (acc && pwrite && paddr == `ACL_REG_CMD && !pslverr)
      lastSvc <= pwdata[7];
  sequence cmdAcc;
    acc && pwrite && paddr == `ACL_REG_CMD && !pslverr;
  endsequence
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready missing after one wait state");
  ready_once_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without a transfer");
  unmapped_err_a: assert property (acc && paddr > 8'h10 |->
    pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  ro_write_a: assert property (acc && pwrite && paddr inside {8'h08, 8'h0C}
    |-> pslverr)
    else $error("read-only write not refused");
  busy_refuse_a: assert property (cmdAcc ##[1:4] (acc && paddr == 8'h00)
    |-> pslverr)
    else $error("stack access taken while busy");
  svc_clear_a: assert property (cmdAcc |=> !svcReq)
    else $error("service request kept after new command");
  svc_cause_a: assert property ($rose(svcReq) |-> lastSvc)
    else $error("service request without its flag");
  irq_mask_a: assert property (acc && pwrite && !pslverr &&
    paddr == `ACL_REG_IRQ_MASK && pwdata[2:0] == 3'h0 |-> ##2 !irq)
    else $error("interrupt stays up with all masked");
endmodule
bind acl_core acl_props #(
  .LN_CYCLES(LN_CYCLES),
  .LOG_CYCLES(LOG_CYCLES)
) chk (
  .core_clk(core_clk),
  .rst_b(rst_b),
  .paddr(paddr),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .svcReq(svcReq),
  .irq(irq)
);
`default_nettype wire

// [verification/acl_host.sv]
`timescale 1ns/1ps
`default_nettype none
module acl_host (
  input  wire logic        core_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output var  logic [7:0]  paddr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [31:0] pwdata
);
  initial begin
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0000_0000;
  end
  // idle address and data inverted so stale values cannot pass
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "acl_defs.vh"
module testbench;
  logic         core_clk = 1'b0;
  logic         rst_b = 1'b0;
  logic [7:0]   paddr;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         svcReq;
  logic         irq;
  logic [31:0]  q;
  logic [31:0]  w;
  logic         e;
  logic         zf;
  logic [127:0] s;
  logic [127:0] x;
  logic [6:0]   op;
  logic [6:0]   moveOps [5] = '{`ACL_OP_ROTW_A, `ACL_OP_ROTW_B,
                  `ACL_OP_ROTN, `ACL_OP_DUPW_A, `ACL_OP_DUPW_B};
  int           a;
  int           b;
  int           num_errors = 0;
  int           comparisons = 0;
  int           cycles = 0;

  always #50 core_clk = ~core_clk;

  acl_host host (
    .core_clk(core_clk),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata)
  );
  // short log counts keep the run brief
  acl_core #(
    .LN_CYCLES(30),
    .LOG_CYCLES(30)
  ) uut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .svcReq(svcReq),
    .irq(irq)
  );

  function automatic logic [31:0] flt(input int v);
    logic [31:0] m;
    int p;
    m = (v < 0) ? -v : v;
    if (m == 0)
      return 32'h0000_0000;
    p = 31;
    while (!m[31]) begin
      m = m << 1;
      p--;
    end
    return {v < 0, 7'(p + 1), m[31:8]};
  endfunction

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    host.xfer(1'b1, ad, d, q, e);
  endtask
  task rd(input logic [7:0] ad);
    host.xfer(1'b0, ad, 32'h0000_0000, q, e);
  endtask
  task push(input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      wr(`ACL_REG_DATA, {24'h00_0000, d[8*i +: 8]});
  endtask
  task pop(output logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      rd(`ACL_REG_DATA);
      d = {d[23:0], q[7:0]};
    end
  endtask
  task load(input logic [127:0] v);
    for (int k = 0; k < 4; k++)
      push(v[32*k +: 32]);
  endtask
  task run(input logic [7:0] c);
    wr(`ACL_REG_CMD, {24'h00_0000, c});
    do rd(`ACL_REG_STATUS); while (q[`ACL_ST_BUSY] !== 1'b0);
  endtask
  task expect_top(input logic [127:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      pop(w);
      check(w, v[127-32*k -: 32]);
    end
  endtask
  task test_done;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    void'($urandom(28137));
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(`ACL_REG_IRQ_MASK);
    check(q, 32'h0000_0000);
    rd(8'h14);
    check({q[30:0], e}, 32'h0000_0001);
    wr(`ACL_REG_STATUS, 32'h0000_0000);
    check({q[30:0], e}, 32'h0000_0001);
    wr(`ACL_REG_IRQ_MASK, 32'h0000_0007);
    for (int i = 0; i < 5; i++) begin
      s = {$urandom, $urandom, $urandom, $urandom};
      op = moveOps[i];
      load(s);
      run({s[0], op});
      if (op == `ACL_OP_ROTN)
        x = {s[111:0], s[127:112]};
      else if (i > 2)
        x = {s[127:96], s[127:32]};
      else
        x = {s[95:0], s[127:96]};
      zf = (op == `ACL_OP_ROTN) ? x[127:112] == 16'h0000 : x[127:96] == 0;
      check({q[6:5], svcReq}, {x[127], zf, s[0]});
      expect_top(x, 4);
    end
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 0 : $urandom_range(1, 24'hFF_FFFF);
      if (i[0])
        a = -a;
      s = {a, $urandom, $urandom, $urandom};
      load(s);
      run({1'b0, `ACL_OP_FLT32});
      check({q[6:5]}, {a < 0, a == 0});
      pop(w);
      check(w, flt(a));
      push(w);
      run({1'b0, `ACL_OP_FIX32});
      expect_top({a, s[95:32], 32'h0000_0000}, 4);
      b = a >>> 9;
      load({flt(b), s[95:0]});
      run({1'b0, `ACL_OP_FIX16});
      expect_top({b[15:0], s[95:32], 48'h0000_0000_0000}, 3);
      load(s);
      a = $signed(s[127:112]);
      run({1'b0, `ACL_OP_FLT16});
      expect_top({flt(a), s[111:48], 32'h0000_0000}, 4);
    end
    for (int i = 0; i < 2; i++) begin
      s = {i ? 32'h1180_0000 : 32'h2880_0000, $urandom, $urandom, $urandom};
      load(s);
      run({1'b0, i ? `ACL_OP_FIX16 : `ACL_OP_FIX32});
      check(q[4:1], `ACL_ERR_OVF);
      expect_top(s, 1);
    end
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 0 : $urandom_range(1, 2047);
      b = $urandom_range(1, 4095);
      if ($urandom_range(0, 1))
        a = -a;
      s = {flt(a), flt(b), $urandom, $urandom};
      load(s);
      run({1'b0, i[0] ? `ACL_OP_FLOAT_MULTIPLY_CMD : `ACL_OP_FLOAT_SUBTRACT_CMD});
      x = {i[0] ? flt(a * b) : flt(b - a), s[63:32], 64'h0};
      expect_top(x, 2);
    end
    load({32'h3F80_0000, 32'h3F80_0000, s[63:0]});
    run({1'b0, `ACL_OP_FLOAT_MULTIPLY_CMD});
    check(q[4:1], `ACL_ERR_OVF);
    expect_top({32'h7D80_0000, s[63:32], 64'h0}, 2);
    for (int i = 0; i < 2; i++) begin
      s = {i ? 32'h0000_0000 : flt(-5), $urandom, $urandom, $urandom};
      load(s);
      run({1'b0, i ? `ACL_OP_LN : `ACL_OP_LOG});
      check(q[4:1], `ACL_ERR_NEG);
      expect_top(s, 2);
    end
    load(s);
    run({1'b1, `ACL_OP_NOP});
    check({q[7:0], svcReq}, 9'h001);
    expect_top(s, 4);
    check(irq, 1'b1);
    rd(`ACL_REG_IRQ_STAT);
    check(q[0], 1'b1);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b0);
    wr(`ACL_REG_CMD, {25'h000_0000, `ACL_OP_ROTW_B});
    wr(`ACL_REG_DATA, 32'h0000_00A5);
    check({q[30:0], e}, 32'h0000_0001);
    do rd(`ACL_REG_STATUS); while (q[`ACL_ST_BUSY] !== 1'b0);
    check(svcReq, 1'b0);
    wr(`ACL_REG_CMD, 32'h0000_007F);
    check(e, 1'b1);
    wr(`ACL_REG_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge core_clk);
    check(irq, 1'b0);
    test_done();
  end
endmodule
`default_nettype wire
